//--- rtl/mjtap_pkg.sv
package mjtap_pkg;

    // Scan register lengths
    localparam int unsigned IR_LEN  = 8;                 // Instruction register width
    localparam int unsigned BSR_LEN = 113;               // Boundary cells, one per ball
    localparam int unsigned ID_LEN  = 32;                // Identification register width

    // Instruction codes
    localparam logic [IR_LEN-1:0] INS_EXTEST  = 8'h00;   // External test
    localparam logic [IR_LEN-1:0] INS_IDCODE  = 8'h21;   // Identification
    localparam logic [IR_LEN-1:0] INS_SAMPLE  = 8'h05;   // Sample / preload
    localparam logic [IR_LEN-1:0] INS_CLAMP   = 8'h07;   // Clamp outputs
    localparam logic [IR_LEN-1:0] INS_HIGHZ   = 8'h03;   // All outputs off
    localparam logic [IR_LEN-1:0] INS_BYPASS  = 8'hff;   // Bypass

    // Values after reset and on capture
    localparam logic [IR_LEN-1:0] IR_RESET    = INS_IDCODE; // Instruction after reset
    localparam logic [IR_LEN-1:0] IR_CAPTURE  = 8'h01;   // Low two bits are binary 01
    localparam logic              BYP_CAPTURE = 1'b0;    // Bypass cell loads low

    // Identification code fields
    localparam int unsigned ID_PRES_POS = 0;             // Presence bit position
    localparam int unsigned ID_VEND_LSB = 1;             // Vendor field 11:1
    localparam int unsigned ID_DEV_LSB  = 12;            // Device field 27:12
    localparam int unsigned ID_REV_LSB  = 28;            // Revision field 31:28
    localparam logic [10:0] ID_VENDOR   = 11'h2b3;       // Arbitrary value
    localparam logic [15:0] ID_DEVICE   = 16'h5a3c;      // Arbitrary value
    localparam logic [3:0]  ID_REVISION = 4'h1;          // Arbitrary value
    localparam logic        ID_PRESENT  = 1'b1;          // Always one

    // Full hardwired code, assembled from the fields
    localparam logic [ID_LEN-1:0] ID_CODE = {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENT};

    // Output balls that the test logic may drive
    localparam logic [BSR_LEN-1:0] OUT_MASK_DEF = 113'h1_ffff_ffff_ffff_ffff_ffff_ffff_ffff;

    // Depth of every two-flop synchroniser
    localparam int unsigned SYNC_STAGES = 2;

    // Controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } mjtap_state_type;

    // Value and enable for every ball
    typedef struct packed {
        logic [BSR_LEN-1:0] val;                         // Level to drive
        logic [BSR_LEN-1:0] oe;                          // Driver enable, high drives
    } mjtap_drive_type;

endpackage

//--- rtl/mjtap_tap.sv
// How it works
// - Sample on rising TCK, drive TDO falling
// - TDI enters MSB, TDO shows LSB
// - TDO driven only in shift states
// - Instruction selects exactly one scan register
// - Five TMS-high edges reach reset harmlessly
// - Power-up reset leaves TDO high-impedance
// - IR updates in Update-IR, resets to IDCODE
// - Capture-IR loads binary 01 low bits
// - Bypass is one cell, captures low
// - Instruction register is eight bits
// - 113-cell boundary register captures, shifts
// - Identification captures hardwired 32-bit code
// - Shift in Shift-IR, effect at Update-IR
// - External test drives outputs, captures inputs
// - High-Z selects bypass, all outputs off
// - Clamp drives outputs from held cells
// - Sample captures all input ball levels
// - Bypass instruction puts one cell in path
// - Open TDI and TMS read high; RTL passes them straight through, left to pad pull-ups
// - Decode the six listed instruction codes
// - ID fields: presence, vendor, device, revision
`timescale 1ns/1ps

module mjtap_tap #(
    parameter logic [mjtap_pkg::BSR_LEN-1:0] OUT_MASK = mjtap_pkg::OUT_MASK_DEF // Output balls
) (
    input  wire logic                        clk_i,      // Memory core clock
    input  wire logic                        rst_n_i,    // Power-up reset, active low
    input  wire logic                        tck_i,      // Test clock, link domain
    input  wire logic                        tms_i,      // Test mode select
    input  wire logic                        tdi_i,      // Test data in
    output logic                             tdo_o,      // Test data out
    output logic                             tdo_oe_o,   // Test data out enable
    input  wire logic [mjtap_pkg::BSR_LEN-1:0] ball_i,   // Levels seen on the balls
    input  mjtap_pkg::mjtap_drive_type       core_i,     // Functional drive from the core
    output mjtap_pkg::mjtap_drive_type       ball_o      // Drive presented to the balls
);

    // Instruction decode of one code against the current instruction
    function automatic logic ins_is(input logic [mjtap_pkg::IR_LEN-1:0] ir,
                                    input logic [mjtap_pkg::IR_LEN-1:0] code);
        ins_is = (ir == code);
    endfunction

    // ---------------- Test clock domain ----------------

    logic                            rst_meta_q;     // Reset synchroniser, first stage
    logic                            rst_sync_q;     // Reset synchroniser, second stage
    logic                            tap_rst_n;      // Reset seen by the TAP logic
    mjtap_pkg::mjtap_state_type      state_q;        // Controller state
    mjtap_pkg::mjtap_state_type      state_d;        // Next controller state
    logic [mjtap_pkg::IR_LEN-1:0]    ir_sh_q;        // Instruction shift stage
    logic [mjtap_pkg::IR_LEN-1:0]    ir_q;           // Active instruction
    logic                            byp_q;          // Bypass cell
    logic [mjtap_pkg::BSR_LEN-1:0]   bsr_sh_q;       // Boundary shift stage
    logic [mjtap_pkg::BSR_LEN-1:0]   bsr_upd_q;      // Boundary held values
    logic [mjtap_pkg::ID_LEN-1:0]    id_sh_q;        // Identification shift stage
    logic [mjtap_pkg::BSR_LEN-1:0]   ball_meta_q;    // Ball synchroniser, first stage
    logic [mjtap_pkg::BSR_LEN-1:0]   ball_sync_q;    // Ball synchroniser, second stage
    logic                            upd_tgl_q;      // Toggles each time the held values are loaded
    logic                            tdo_q;          // Output bit, falling edge
    logic                            tdo_oe_q;       // Output enable, falling edge
    logic                            drive_q;        // Test drive mode, registered
    logic                            off_q;          // Outputs-off mode, registered

    // Instruction classes; each compares the whole eight-bit code,
    // so a code one bit away from a listed one never matches it
    wire logic is_extest = ins_is(ir_q, mjtap_pkg::INS_EXTEST);
    wire logic is_idcode = ins_is(ir_q, mjtap_pkg::INS_IDCODE);
    wire logic is_sample = ins_is(ir_q, mjtap_pkg::INS_SAMPLE);
    wire logic is_clamp  = ins_is(ir_q, mjtap_pkg::INS_CLAMP);
    wire logic is_highz  = ins_is(ir_q, mjtap_pkg::INS_HIGHZ);

    // Path selection; anything else, reserved codes too, falls to bypass
    wire logic sel_bsr   = is_extest | is_sample;
    wire logic sel_id    = is_idcode;
    wire logic sel_byp   = ~sel_bsr & ~sel_id;

    // Test drive modes handed to the core side
    wire logic mode_drive = is_extest | is_clamp;
    wire logic mode_off   = is_highz;

    // State decodes
    wire logic in_cap_dr   = (state_q == mjtap_pkg::ST_CAP_DR);
    wire logic in_shift_dr = (state_q == mjtap_pkg::ST_SHIFT_DR);
    wire logic in_upd_dr   = (state_q == mjtap_pkg::ST_UPD_DR);
    wire logic in_cap_ir   = (state_q == mjtap_pkg::ST_CAP_IR);
    wire logic in_shift_ir = (state_q == mjtap_pkg::ST_SHIFT_IR);
    wire logic in_upd_ir   = (state_q == mjtap_pkg::ST_UPD_IR);
    wire logic in_reset    = (state_q == mjtap_pkg::ST_RESET);

    // Bit presented at TDO: least significant bit of the selected register
    wire logic dr_lsb  = sel_bsr ? bsr_sh_q[0] : (sel_id ? id_sh_q[0] : byp_q);
    wire logic tdo_bit = in_shift_ir ? ir_sh_q[0] : dr_lsb;

    // Unconnected TDI and TMS read high through pad pull-ups, so a floating
    // TMS walks the controller into reset.
    wire logic tms_bit = tms_i;
    wire logic tdi_bit = tdi_i;

    // Power-up reset into the test clock domain; assert at once, release on TCK
    always_ff @(posedge tck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign tap_rst_n = rst_sync_q;

    // Controller next state
    // Data column first, then the instruction column; each state
    // leaves on one TMS level and stays or moves on the other
    always_comb begin
        state_d = state_q;
        case (state_q)
            mjtap_pkg::ST_RESET:    state_d = tms_bit ? mjtap_pkg::ST_RESET    : mjtap_pkg::ST_IDLE;
            mjtap_pkg::ST_IDLE:     state_d = tms_bit ? mjtap_pkg::ST_SEL_DR   : mjtap_pkg::ST_IDLE;
            mjtap_pkg::ST_SEL_DR:   state_d = tms_bit ? mjtap_pkg::ST_SEL_IR   : mjtap_pkg::ST_CAP_DR;
            mjtap_pkg::ST_CAP_DR:   state_d = tms_bit ? mjtap_pkg::ST_EXIT1_DR : mjtap_pkg::ST_SHIFT_DR;
            mjtap_pkg::ST_SHIFT_DR: state_d = tms_bit ? mjtap_pkg::ST_EXIT1_DR : mjtap_pkg::ST_SHIFT_DR;
            mjtap_pkg::ST_EXIT1_DR: state_d = tms_bit ? mjtap_pkg::ST_UPD_DR   : mjtap_pkg::ST_PAUSE_DR;
            mjtap_pkg::ST_PAUSE_DR: state_d = tms_bit ? mjtap_pkg::ST_EXIT2_DR : mjtap_pkg::ST_PAUSE_DR;
            mjtap_pkg::ST_EXIT2_DR: state_d = tms_bit ? mjtap_pkg::ST_UPD_DR   : mjtap_pkg::ST_SHIFT_DR;
            mjtap_pkg::ST_UPD_DR:   state_d = tms_bit ? mjtap_pkg::ST_SEL_DR   : mjtap_pkg::ST_IDLE;
            mjtap_pkg::ST_SEL_IR:   state_d = tms_bit ? mjtap_pkg::ST_RESET    : mjtap_pkg::ST_CAP_IR;
            mjtap_pkg::ST_CAP_IR:   state_d = tms_bit ? mjtap_pkg::ST_EXIT1_IR : mjtap_pkg::ST_SHIFT_IR;
            mjtap_pkg::ST_SHIFT_IR: state_d = tms_bit ? mjtap_pkg::ST_EXIT1_IR : mjtap_pkg::ST_SHIFT_IR;
            mjtap_pkg::ST_EXIT1_IR: state_d = tms_bit ? mjtap_pkg::ST_UPD_IR   : mjtap_pkg::ST_PAUSE_IR;
            mjtap_pkg::ST_PAUSE_IR: state_d = tms_bit ? mjtap_pkg::ST_EXIT2_IR : mjtap_pkg::ST_PAUSE_IR;
            mjtap_pkg::ST_EXIT2_IR: state_d = tms_bit ? mjtap_pkg::ST_UPD_IR   : mjtap_pkg::ST_SHIFT_IR;
            mjtap_pkg::ST_UPD_IR:   state_d = tms_bit ? mjtap_pkg::ST_SEL_DR   : mjtap_pkg::ST_IDLE;
            default:                state_d = mjtap_pkg::ST_RESET;
        endcase
    end

    // Controller state register; from any state five TMS-high edges land in reset
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_q <= mjtap_pkg::ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Instruction shift stage: capture pattern, then shift toward the LSB
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sh_q <= mjtap_pkg::IR_CAPTURE;
        end else if (in_cap_ir) begin
            ir_sh_q <= mjtap_pkg::IR_CAPTURE;
        end else if (in_shift_ir) begin
            ir_sh_q <= {tdi_bit, ir_sh_q[mjtap_pkg::IR_LEN-1:1]};
        end
    end

    // Active instruction: changes on the Update-IR edge, and reloads IDCODE in Test-Logic-Reset
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_q <= mjtap_pkg::IR_RESET;
        end else if (in_reset) begin
            ir_q <= mjtap_pkg::IR_RESET;
        end else if (in_upd_ir) begin
            ir_q <= ir_sh_q;
        end
    end

    // Bypass cell: loads low on capture, one stage from TDI to TDO
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_q <= mjtap_pkg::BYP_CAPTURE;
        end else if (sel_byp && in_cap_dr) begin
            byp_q <= mjtap_pkg::BYP_CAPTURE;
        end else if (sel_byp && in_shift_dr) begin
            byp_q <= tdi_bit;
        end
    end

    // Ball levels pass two flops before the boundary capture reads them
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ball_meta_q <= '0;
            ball_sync_q <= '0;
        end else begin
            ball_meta_q <= ball_i;
            ball_sync_q <= ball_meta_q;
        end
    end

    // Boundary shift stage: capture ring levels, then shift toward the LSB
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr_sh_q <= '0;
        end else if (sel_bsr && in_cap_dr) begin
            bsr_sh_q <= ball_sync_q;
        end else if (sel_bsr && in_shift_dr) begin
            bsr_sh_q <= {tdi_bit, bsr_sh_q[mjtap_pkg::BSR_LEN-1:1]};
        end
    end

    // Held boundary values, loaded on Update-DR under either boundary instruction
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr_upd_q <= '0;
            upd_tgl_q <= 1'b0;
        end else if (sel_bsr && in_upd_dr) begin
            bsr_upd_q <= bsr_sh_q;
            upd_tgl_q <= ~upd_tgl_q;
        end
    end

    // Identification stage: hardwired code on capture, shift toward the LSB
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            id_sh_q <= mjtap_pkg::ID_CODE;
        end else if (sel_id && in_cap_dr) begin
            id_sh_q <= mjtap_pkg::ID_CODE;
        end else if (sel_id && in_shift_dr) begin
            id_sh_q <= {tdi_bit, id_sh_q[mjtap_pkg::ID_LEN-1:1]};
        end
    end

    // TDO and its enable change on the falling edge, enabled only while shifting
    always_ff @(negedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_bit;
            tdo_oe_q <= in_shift_ir | in_shift_dr;
        end
    end

    assign tdo_o    = tdo_q;
    assign tdo_oe_o = tdo_oe_q;

    // Mode levels leave the test domain from flops, so no decode glitch
    // of the instruction bits can be caught by the core synchroniser
    always_ff @(posedge tck_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            drive_q <= 1'b0;
            off_q   <= 1'b0;
        end else begin
            drive_q <= mode_drive;
            off_q   <= mode_off;
        end
    end

    // ---------------- Core clock domain ----------------
    //
    // Only single-bit levels and one toggle cross from the test domain;
    // the wide held word is read after its toggle has settled, and the
    // functional core drive never passes through the test clock.

    logic [mjtap_pkg::SYNC_STAGES-1:0] drv_sync_q;   // Drive-mode level synchroniser
    logic [mjtap_pkg::SYNC_STAGES-1:0] off_sync_q;   // Off-mode level synchroniser
    logic [mjtap_pkg::SYNC_STAGES-1:0] tgl_sync_q;   // Update toggle synchroniser
    logic                              tgl_seen_q;   // Last toggle level taken
    logic [mjtap_pkg::BSR_LEN-1:0]     held_q;       // Boundary values in this domain
    mjtap_pkg::mjtap_drive_type        ball_q;       // Registered ball drive
    mjtap_pkg::mjtap_drive_type        ball_d;       // Next ball drive

    // A new held word is announced by a toggle edge; the word itself stays
    // still for many core cycles, because TCK is far slower than the core clock
    wire logic tgl_edge = tgl_sync_q[1] ^ tgl_seen_q;

    // Mode levels and the toggle pass two flops each
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_sync_q <= '0;
            off_sync_q <= '0;
            tgl_sync_q <= '0;
            tgl_seen_q <= 1'b0;
        end else begin
            drv_sync_q <= {drv_sync_q[0], drive_q};
            off_sync_q <= {off_sync_q[0], off_q};
            tgl_sync_q <= {tgl_sync_q[0], upd_tgl_q};
            tgl_seen_q <= tgl_sync_q[1];
        end
    end

    // Take the held word once its toggle has crossed; by then the word
    // has stood still for more than two core clock periods
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held_q <= '0;
        end else if (tgl_edge) begin
            held_q <= bsr_upd_q;
        end
    end

    // Ball drive selection: off, test drive, or functional core drive
    // Off wins, so a mode change can never let a held value out early
    always_comb begin
        ball_d = core_i;
        if (off_sync_q[1]) begin
            ball_d.val = core_i.val;
            ball_d.oe  = '0;
        end else if (drv_sync_q[1]) begin
            ball_d.val = held_q;
            ball_d.oe  = OUT_MASK;
        end
    end

    // Registered ball outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ball_q <= '0;
        end else begin
            ball_q <= ball_d;
        end
    end

    assign ball_o = ball_q;

endmodule // mjtap_tap

//--- verif/memory_jtag_boundary_scan_tap_tb.sv
`timescale 1ns/1ps
module memory_jtag_boundary_scan_tap_tb;
    localparam int unsigned BL = mjtap_pkg::BSR_LEN;
    localparam logic [31:0] ID_EXP = {mjtap_pkg::ID_REVISION, mjtap_pkg::ID_DEVICE,
        mjtap_pkg::ID_VENDOR, 1'b1};
    logic                       clk_i;   // Core clock
    logic                       rst_n_i; // Reset, active low
    logic                       tck;     // Test clock
    logic                       tms;     // Mode select
    logic                       tdi;     // Data in
    logic                       tdo;     // Data out
    logic                       tdo_oe;  // Data out enable
    logic [BL-1:0]              ball_i;  // Board levels
    mjtap_pkg::mjtap_drive_type core_i;  // Core drive
    mjtap_pkg::mjtap_drive_type ball_o;  // Ball drive
    mjtap_pkg::mjtap_drive_type exp_d;   // Expected ball drive
    logic [BL-1:0]              held;    // Expected held cells
    logic [159:0]               din;     // Bits shifted in
    logic [159:0]               dout;    // Bits seen out
    logic [159:0]               exp_v;   // Bits expected out
    logic                       ok;      // Enable window right
    int                         mismatches = 0;
    int                         checked = 0;
    // Sample first, so the held word is known for the drive modes
    logic [7:0] codes [7] = '{mjtap_pkg::INS_SAMPLE, mjtap_pkg::INS_EXTEST, mjtap_pkg::INS_CLAMP,
        mjtap_pkg::INS_HIGHZ, mjtap_pkg::INS_BYPASS, mjtap_pkg::INS_EXTEST, mjtap_pkg::INS_IDCODE};
    mjtap_tap i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ball_i(ball_i), .core_i(core_i), .ball_o(ball_o));
    mjtap_tester i_tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
    // Random word as wide as the boundary register
    function automatic logic [BL-1:0] rnd_cells();
        return BL'({$urandom(), $urandom(), $urandom(), $urandom()});
    endfunction
    // Scan path length chosen by the instruction
    function automatic int path_len(input logic [7:0] c);
        if (c === mjtap_pkg::INS_IDCODE) return 32;
        if (c === mjtap_pkg::INS_EXTEST || c === mjtap_pkg::INS_SAMPLE) return 113;
        return 1;
    endfunction
    // Captured word first, then the shifted-in bits
    function automatic logic [159:0] scan_exp(input logic [7:0] c, input logic [159:0] d);
        logic [159:0] cap;
        cap = '0;
        if (c === mjtap_pkg::INS_IDCODE) cap = 160'(ID_EXP);
        if (path_len(c) == 113) cap = 160'(ball_i);
        return (d << path_len(c)) | cap;
    endfunction
    // Compare and count
    task automatic check(input logic [159:0] seen, input logic [159:0] expv);
        checked++;
        if (seen !== expv) begin
            mismatches++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, expv);
        end
    endtask
    // Counts, verdict, end of run
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Core clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Hang guard
    initial begin
        #300us;
        mismatches++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        ball_i = '0;
        core_i = '0;
        held = '0;
        void'($urandom(64877));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        i_tester.reset_tap();
        @(posedge clk_i);
        i_tester.scan(1'b0, 32, '0, dout, ok);
        check(160'(dout[31:0]), 160'(ID_EXP));
        // Every instruction: capture, path, ball drive
        foreach (codes[i]) begin
            @(posedge clk_i);
            ball_i <= rnd_cells();
            core_i <= {rnd_cells(), rnd_cells()};
            i_tester.scan(1'b1, 8, 160'(codes[i]), dout, ok);
            check(160'(dout[1:0]), 160'(2'b01));
            din = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
            exp_v = scan_exp(codes[i], din);
            @(posedge clk_i);
            i_tester.scan(1'b0, 150, din, dout, ok);
            check(160'(dout[149:0]), 160'(exp_v[149:0]));
            check(160'(ok), 160'(1'b1));
            if (path_len(codes[i]) == 113) held = din[149:37];
            repeat (8) @(posedge clk_i);
            exp_d = core_i;
            if (codes[i] === mjtap_pkg::INS_EXTEST || codes[i] === mjtap_pkg::INS_CLAMP) begin
                exp_d = {held, mjtap_pkg::OUT_MASK_DEF};
            end
            if (codes[i] === mjtap_pkg::INS_HIGHZ) exp_d.oe = '0;
            check(160'(ball_o.oe), 160'(exp_d.oe));
            if (codes[i] !== mjtap_pkg::INS_HIGHZ) check(160'(ball_o.val), 160'(exp_d.val));
        end
        // Leave Shift-DR by five high TMS; second pass under a core reset
        for (int r = 0; r < 2; r++) begin
            @(posedge clk_i);
            i_tester.scan(1'b1, 8, 160'(mjtap_pkg::INS_BYPASS), dout, ok);
            @(posedge clk_i);
            #1;
            i_tester.tick(1'b1, 1'b1);
            repeat (2) i_tester.tick(1'b0, 1'b0);
            @(posedge clk_i);
            rst_n_i <= (r == 0);
            i_tester.reset_tap();
            @(posedge clk_i);
            rst_n_i <= 1'b1;
            i_tester.reset_tap();
            @(posedge clk_i);
            i_tester.scan(1'b0, 32, '0, dout, ok);
            check(160'(dout[31:0]), 160'(ID_EXP));
        end
        tally_and_finish();
    end
endmodule // memory_jtag_boundary_scan_tap_tb

//--- verif/mjtap_assertions.sv
`timescale 1ns/1ps
// Port-level watch of the scan port and the ball drive
module mjtap_assertions #(
    parameter logic [mjtap_pkg::BSR_LEN-1:0] OUT_MASK = mjtap_pkg::OUT_MASK_DEF // Drivable balls
) (
    input wire logic                  clk_i,    // Core clock
    input wire logic                  rst_n_i,  // Reset, active low
    input wire logic                  tck_i,    // Test clock
    input wire logic                  tms_i,    // Mode select
    input wire logic                  tdo_o,    // Data out
    input wire logic                  tdo_oe_o, // Data out enable
    input mjtap_pkg::mjtap_drive_type core_i,   // Core drive
    input mjtap_pkg::mjtap_drive_type ball_o    // Ball drive
);
    property p_tdo_fall;
        @(posedge clk_i) disable iff (!rst_n_i) $changed(tdo_o) |-> $past(tck_i) && !tck_i;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling tck");
    property p_oe_fall;
        @(posedge clk_i) disable iff (!rst_n_i) $changed(tdo_oe_o) |-> $past(tck_i) && !tck_i;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved off falling tck");
    property p_reset_quiet;
        @(posedge clk_i) disable iff (!rst_n_i) $rose(rst_n_i) |-> !tdo_oe_o && ball_o == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("port busy after reset");
    property p_ball_oe;
        @(posedge clk_i) disable iff (!rst_n_i) (ball_o.oe & ~(OUT_MASK | $past(core_i.oe))) == '0;
    endproperty
    a_ball_oe: assert property (p_ball_oe) else $error("ball driven outside allowed set");
    property p_five_tms;
        @(posedge tck_i) disable iff (!rst_n_i) tms_i [*5] |=> !tdo_oe_o;
    endproperty
    a_five_tms: assert property (p_five_tms) else $error("tdo enabled after five high tms");
    property p_oe_hold;
        @(posedge tck_i) disable iff (!rst_n_i) tdo_oe_o && !tms_i |=> tdo_oe_o;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("shift left with tms low");
    property p_oe_leave;
        @(posedge tck_i) disable iff (!rst_n_i) tdo_oe_o && tms_i |=> !tdo_oe_o;
    endproperty
    a_oe_leave: assert property (p_oe_leave) else $error("shift kept with tms high");
    property p_oe_start;
        @(posedge tck_i) disable iff (!rst_n_i) $rose(tdo_oe_o) |-> !$past(tms_i);
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("shift entered with tms high");
    c_shift: cover property (@(posedge tck_i) $rose(tdo_oe_o));
    c_tms_reset: cover property (@(posedge tck_i) tms_i [*5]);
    c_drive: cover property (@(posedge clk_i) ball_o.oe == OUT_MASK);
endmodule // mjtap_assertions
bind mjtap_tap mjtap_assertions #(.OUT_MASK(OUT_MASK)) i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .core_i(core_i), .ball_o(ball_o));

//--- verif/mjtap_tester.sv
`timescale 1ns/1ps
// Behavioural scan tester; its clock stands low between frames
// Sends no memory commands: it drives only TCK, TMS and TDI
// and reads TDO and its enable
module mjtap_tester (
    output logic      tck_o,   // Test clock, 48 ns
    output logic      tms_o,   // Mode select
    output logic      tdi_o,   // Data to the port
    input  wire logic tdo_i,   // Data from the port
    input  wire logic tdo_oe_i // Port driver enable
);
    logic seen_q; // Data out just before a rise
    logic en_q;   // Enable just before a rise
    wire logic tdo_pin = tdo_oe_i ? tdo_i : ~tdo_i; // Released pin shows no stale level
    // Open pins read high
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // One period; inputs move while the clock is low
    task automatic tick(input logic tms, input logic tdi);
        tms_o <= tms;
        tdi_o <= tdi;
        #24;
        seen_q = tdo_pin;
        en_q = tdo_oe_i;
        tck_o <= 1'b1;
        #24;
        tck_o <= 1'b0;
    endtask
    // Five high edges reach reset from any state, then idle
    task automatic reset_tap();
        #1;
        repeat (5) tick(1'b1, 1'b1);
        tick(1'b0, 1'b1);
    endtask
    // Idle, shift n bits LSB first, update, idle again
    task automatic scan(input logic ir, input int n, input logic [159:0] din,
                        output logic [159:0] dout, output logic oe_ok);
        dout = '0;
        oe_ok = 1'b1;
        #1;
        tick(1'b1, 1'b1);
        if (ir) tick(1'b1, 1'b1);
        repeat (2) tick(1'b0, 1'b1);
        for (int k = 0; k < n; k++) begin
            tick(k == n - 1, din[k]);
            dout[k] = seen_q;
            oe_ok = oe_ok & en_q;
        end
        tick(1'b1, 1'b1);
        oe_ok = oe_ok & ~en_q;
        tick(1'b0, 1'b1);
    endtask
endmodule // mjtap_tester
